// *** dis_top.v ***
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dis_map.vh"
module dis_top (
	input wire clk,
	input wire resetn,
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_n,
	input wire addr_select_pin,
	output reg [15:0] dac_value,
	output reg dac_update,
	output reg [2:0] powerdown_flag,
	output reg hs_mode,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam ST_IDLE = 3'd0;
	localparam ST_RX = 3'd1;
	localparam ST_RXACK = 3'd2;
	localparam ST_TX = 3'd3;
	localparam ST_TXACK = 3'd4;

	wire scl_s;
	wire sda_s;
	wire sel_s;
	reg scl_p_q;
	reg sda_p_q;
	reg [1:0] cap_cnt_q;
	reg sel_cap_q;
	reg [2:0] st_q;
	reg [3:0] bit_q;
	reg [1:0] ph_q;
	reg [1:0] rdi_q;
	reg rd_q;
	reg mack_q;
	reg [7:0] sh_q;
	reg [7:0] tx_q;
	reg [7:0] ctrl_q;
	reg [7:0] hi_q;
	reg [7:0] lo_q;
	reg [15:0] temp_q;
	reg [2:0] temp_pd_q;
	reg [15:0] upd_cnt_q;
	reg en_q;
	reg cnt_clr_q;
	reg aw_got_q;
	reg w_got_q;
	reg [7:0] aw_addr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	dis_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.async_i({addr_select_pin, sda_i, scl_i}),
		.sync_o({sel_s, sda_s, scl_s})
	);

	wire scl_rise = scl_s & ~scl_p_q;
	wire scl_fall = ~scl_s & scl_p_q;
	// Data moving while clock high is a bus condition, never a bit
	wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

	wire [1:0] mode = ctrl_q[5:4];
	wire brc_sel = ctrl_q[2];
	wire [15:0] rx_word = {hi_q, lo_q};
	wire [2:0] pd_new = ctrl_q[0] ? hi_q[7:5] : 3'b000;
	wire load_new = (mode == `DIS_MODE_LOAD) | ((mode == `DIS_MODE_BCAST) & brc_sel);
	wire load_tmp = (mode == `DIS_MODE_FROMTMP) | ((mode == `DIS_MODE_BCAST) & ~brc_sel);
	wire store_tmp = (mode == `DIS_MODE_TEMP) | load_new;
	// Broadcast mode ignores the top control bits
	wire upd_ok = (ctrl_q[7:6] == 2'b00) | (mode == `DIS_MODE_BCAST);
	wire addr_own = (sh_q[7:1] == {`DIS_ADDR_FIX, sel_cap_q, 1'b0});
	wire addr_bc = (sh_q == `DIS_BCAST);
	wire is_hs = (sh_q[7:3] == `DIS_HS_CODE);
	// Source follows control bits so the master can tell them apart
	wire [15:0] rd_word = load_new ? dac_value :
		((mode == `DIS_MODE_TEMP) ? temp_q : rx_word);
	wire [1:0] rdi_n = (rdi_q == 2'd2) ? 2'd0 : rdi_q + 2'd1;

	function [7:0] tx_byte;
		input [1:0] idx;
		begin
			case (idx)
				2'd0: tx_byte = rd_word[15:8];
				2'd1: tx_byte = rd_word[7:0];
				default: tx_byte = ctrl_q;
			endcase
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `DIS_REG_CFG) | (a == `DIS_REG_STATUS) |
				(a == `DIS_REG_DAC) | (a == `DIS_REG_TEMP) |
				(a == `DIS_REG_CTRLB) | (a == `DIS_REG_UPDCNT);
		end
	endfunction

	wire [7:0] txb0 = tx_byte(2'd0);
	wire [7:0] txb_n = tx_byte(rdi_n);

	// Pin level caught once the synchroniser has settled after release
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cap_cnt_q <= 2'd0;
			sel_cap_q <= 1'b0;
		end else if (cap_cnt_q != `DIS_CAP_WAIT) begin
			cap_cnt_q <= cap_cnt_q + 2'd1;
			if (cap_cnt_q == `DIS_CAP_WAIT - 2'd1) begin
				sel_cap_q <= sel_s;
			end
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_IDLE;
			bit_q <= 4'd0;
			ph_q <= 2'd0;
			rdi_q <= 2'd0;
			rd_q <= 1'b0;
			mack_q <= 1'b0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ctrl_q <= 8'h00;
			hi_q <= 8'h00;
			lo_q <= 8'h00;
			temp_q <= 16'h0000;
			temp_pd_q <= 3'b000;
			dac_value <= 16'h0000;
			powerdown_flag <= 3'b000;
			dac_update <= 1'b0;
			hs_mode <= 1'b0;
			upd_cnt_q <= 16'h0000;
			sda_o <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			dac_update <= 1'b0;
			if (cnt_clr_q) begin
				upd_cnt_q <= 16'h0000;
			end
			if (stop_c) begin
				// Stored data stays; only the bus state is dropped
				st_q <= ST_IDLE;
				hs_mode <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (start_c) begin
				// Repeated start also restarts at the address byte
				st_q <= ST_RX;
				bit_q <= 4'd0;
				ph_q <= 2'd0;
				sda_oe_n <= 1'b1;
			end else begin
				case (st_q)
					ST_RX: begin
						if (scl_rise && bit_q != 4'd8) begin
							sh_q <= {sh_q[6:0], sda_s};
							bit_q <= bit_q + 4'd1;
						end else if (scl_fall && bit_q == 4'd8) begin
							bit_q <= 4'd0;
							if (ph_q == 2'd0) begin
								if (is_hs) begin
									hs_mode <= 1'b1;
									st_q <= ST_IDLE;
								end else if (en_q && addr_own) begin
									sda_oe_n <= 1'b0;
									rd_q <= sh_q[0];
									st_q <= ST_RXACK;
								end else if (en_q && addr_bc) begin
									sda_oe_n <= 1'b0;
									rd_q <= 1'b0;
									st_q <= ST_RXACK;
								end else begin
									st_q <= ST_IDLE;
								end
							end else begin
								sda_oe_n <= 1'b0;
								st_q <= ST_RXACK;
								case (ph_q)
									2'd1: ctrl_q <= sh_q;
									2'd2: hi_q <= sh_q;
									default: lo_q <= sh_q;
								endcase
							end
						end
					end
					ST_RXACK: begin
						if (scl_fall) begin
							bit_q <= 4'd0;
							if (ph_q == 2'd0 && rd_q) begin
								tx_q <= txb0;
								rdi_q <= 2'd0;
								sda_oe_n <= txb0[7];
								st_q <= ST_TX;
							end else begin
								sda_oe_n <= 1'b1;
								st_q <= ST_RX;
								// After a low byte, loop on data pairs only
								ph_q <= (ph_q == 2'd3) ? 2'd2 : ph_q + 2'd1;
								if (ph_q == 2'd3 && upd_ok) begin
									upd_cnt_q <= cnt_clr_q ? 16'h0001 : upd_cnt_q + 16'h0001;
									if (store_tmp) begin
										temp_q <= rx_word;
										temp_pd_q <= pd_new;
									end
									if (load_new) begin
										dac_value <= rx_word;
										powerdown_flag <= pd_new;
										dac_update <= 1'b1;
									end else if (load_tmp) begin
										dac_value <= temp_q;
										powerdown_flag <= temp_pd_q;
										dac_update <= 1'b1;
									end
								end
							end
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							bit_q <= bit_q + 4'd1;
							if (bit_q == 4'd7) begin
								sda_oe_n <= 1'b1;
								st_q <= ST_TXACK;
							end else begin
								sda_oe_n <= tx_q[6];
								tx_q <= {tx_q[6:0], 1'b0};
							end
						end
					end
					ST_TXACK: begin
						if (scl_rise) begin
							mack_q <= ~sda_s;
						end else if (scl_fall) begin
							bit_q <= 4'd0;
							if (mack_q) begin
								rdi_q <= rdi_n;
								tx_q <= txb_n;
								sda_oe_n <= txb_n[7];
								st_q <= ST_TX;
							end else begin
								st_q <= ST_IDLE;
							end
						end
					end
					default: begin
						sda_oe_n <= 1'b1;
					end
				endcase
			end
		end
	end

	// Write and address are taken in either order, answered together
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DIS_RESP_OK;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			en_q <= `DIS_CFG_RESET;
			cnt_clr_q <= 1'b0;
		end else begin
			cnt_clr_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_awaddr;
				aw_got_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_got_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr_q) ? `DIS_RESP_OK : `DIS_RESP_ERR;
				if (aw_addr_q == `DIS_REG_CFG && wstrb_q[0]) begin
					en_q <= wdata_q[`DIS_CFG_EN];
					cnt_clr_q <= wdata_q[`DIS_CFG_CLR];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `DIS_RESP_OK;
			s_axi_rdata <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? `DIS_RESP_OK : `DIS_RESP_ERR;
			case (s_axi_araddr)
				`DIS_REG_CFG: s_axi_rdata <= {31'h00000000, en_q};
				`DIS_REG_STATUS: s_axi_rdata <= {24'h000000, st_q, powerdown_flag,
					sel_cap_q, hs_mode};
				`DIS_REG_DAC: s_axi_rdata <= {16'h0000, dac_value};
				`DIS_REG_TEMP: s_axi_rdata <= {13'h0000, temp_pd_q, temp_q};
				`DIS_REG_CTRLB: s_axi_rdata <= {24'h000000, ctrl_q};
				`DIS_REG_UPDCNT: s_axi_rdata <= {16'h0000, upd_cnt_q};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** dis_map.vh ***
// Functional notes
// - Master code unacknowledged; enter high-speed handling.
// - Transmitter keeps data stable while clock high.
// - Ninth clock carries acknowledge from receiver.
// - Stop ends high-speed handling.
// - Read sends high byte first, MSB first.
// - Acked high byte, then low, then control.
// - Readback source shown by returned control bits.
// - First update needs start, address, control, data.
// - Acknowledge every received write byte.
// - Update at falling edge ending low ack.
// - Repeated data pairs update using last control.
// - Each later update takes eighteen clocks.
// - Address byte is 10011, select, zero, direction.
// - Select bit must equal captured pin level.
// - Capture select pin level after reset.
// - Last address bit one reads, zero writes.
// - Broadcast address accepted regardless of select pin.
// - Broadcast address only for writes.
// - Nonzero top control bits block non-broadcast updates.
// - Control bits five, four select update mode.
// - Power-down flag makes top bits a command.
`ifndef DIS_MAP_VH
`define DIS_MAP_VH
`define DIS_REG_CFG 8'h00
`define DIS_REG_STATUS 8'h04
`define DIS_REG_DAC 8'h08
`define DIS_REG_TEMP 8'h0c
`define DIS_REG_CTRLB 8'h10
`define DIS_REG_UPDCNT 8'h14
`define DIS_CFG_EN 0
`define DIS_CFG_CLR 1
`define DIS_CFG_RESET 1'b1
`define DIS_ADDR_FIX 5'h13
`define DIS_BCAST 8'h90
`define DIS_HS_CODE 5'h01
`define DIS_CAP_WAIT 2'd3
`define DIS_RESP_OK 2'b00
`define DIS_RESP_ERR 2'b10
`define DIS_MODE_TEMP 2'b00
`define DIS_MODE_LOAD 2'b01
`define DIS_MODE_FROMTMP 2'b10
`define DIS_MODE_BCAST 2'b11
`endif

// *** dis_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module dis_sync (
	input wire clk,
	input wire resetn,
	input wire [2:0] async_i,
	output wire [2:0] sync_o
);
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_sync
			reg meta_q;
			reg stab_q;
			// Idle bus level is high, so reset to one
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					meta_q <= 1'b1;
					stab_q <= 1'b1;
				end else begin
					meta_q <= async_i[i];
					stab_q <= meta_q;
				end
			end
			assign sync_o[i] = stab_q;
		end
	endgenerate
endmodule
`default_nettype wire

// *** dis_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module dis_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_oe_n,
	input wire logic dac_update,
	input wire logic hs_mode,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence stop_seen;
		scl_i && $rose(sda_i);
	endsequence
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_i)
		else $error("data pulled low while clock high");
	a_hold_clock_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n))
		else $error("data changed while clock high");
	a_drive_bounded: assert property ($fell(sda_oe_n) |-> ##[1:80] sda_oe_n)
		else $error("data held low too long");
	a_update_one_pulse: assert property (dac_update |=> !dac_update)
		else $error("update pulse too long");
	// Sync delay puts the pulse a few cycles after the pin fall
	a_update_clock_low: assert property (dac_update |-> !$past(scl_i, 3))
		else $error("update not after clock fall");
	a_stop_ends_hs: assert property (stop_seen |-> ##[1:8] !hs_mode)
		else $error("high speed kept after stop");
	a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read data late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule
bind dis_top dis_chk chk_u (.clk(clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i),
	.sda_oe_n(sda_oe_n), .dac_update(dac_update), .hs_mode(hs_mode),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// *** dis_bus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dis_bus_master_model (
	output logic scl,
	output logic sda_rel,
	input wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// Odd offset keeps bus edges off the system clock edges
	task automatic start_c;
		#17;
		sda_rel = 1'b1;
		#100;
		scl = 1'b1;
		#100;
		sda_rel = 1'b0;
		#100;
		scl = 1'b0;
		#100;
	endtask
	task automatic stop_c;
		sda_rel = 1'b0;
		#100;
		scl = 1'b1;
		#100;
		sda_rel = 1'b1;
		#200;
	endtask
	task automatic bit_x(input logic bv, output logic s);
		sda_rel = bv;
		#100;
		scl = 1'b1;
		#100;
		s = sda_line;
		#100;
		scl = 1'b0;
		#100;
	endtask
	task automatic wr_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(v[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	task automatic rd_byte(input logic ack, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, v[i]);
		bit_x(!ack, s);
	endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [23:0] BAD = 24'h9a9188;
	logic clk, resetn, sel, scl, sda_rel, sda_o, sda_oe_n, upd, hs;
	logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [7:0] awa, ara, b;
	logic [31:0] wd, rd, d;
	logic [1:0] bres, rres, r;
	logic [15:0] dac, v, u;
	logic [2:0] pd;
	logic [15:0] exp_q[$];
	int err_total, comparisons;
	wire sda;
	assign sda = sda_rel & (sda_oe_n | sda_o);
	dis_top dut_u (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .addr_select_pin(sel), .dac_value(dac), .dac_update(upd),
		.powerdown_flag(pd), .hs_mode(hs), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr));
	dis_bus_master_model m_u (.scl(scl), .sda_rel(sda_rel), .sda_line(sda));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task print_verdict;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge clk);
		n++;
		if (n > 100) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, n, 100);
			print_verdict();
		end
	endtask
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		awa <= ad;
		wd <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		while (!(aw && w)) begin
			tick(n);
			aw = aw | (awv & awr);
			w = w | (wv & wr);
			awv <= !aw;
			wv <= !w;
		end
		br <= 1'b1;
		do tick(n); while (bv !== 1'b1);
		rs = bres;
		br <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk);
		ara <= ad;
		arv <= 1'b1;
		do tick(n); while (arr !== 1'b1);
		arv <= 1'b0;
		// Late ready makes the slave hold its answer
		@(posedge clk);
		rr <= 1'b1;
		do tick(n); while (rv !== 1'b1);
		dt = rd;
		rs = rres;
		rr <= 1'b0;
	endtask
	task automatic send(input logic [7:0] bt, input logic ex);
		logic ak;
		m_u.wr_byte(bt, ak);
		chk({31'h0, ak}, {31'h0, ex});
	endtask
	task automatic frame(input logic [7:0] ad, input logic [7:0] c, input logic [15:0] dv);
		m_u.start_c();
		send(ad, 1'b1);
		send(c, 1'b1);
		send(dv[15:8], 1'b1);
		send(dv[7:0], 1'b1);
	endtask
	always @(negedge clk) begin
		if (resetn && upd === 1'b1) begin
			if (exp_q.size() == 0)
				chk({16'h0, dac}, 32'hffffffff);
			else
				chk({16'h0, dac}, {16'h0, exp_q.pop_front()});
		end
	end
	initial begin
		#3000000;
		err_total++;
		print_verdict();
	end
	initial begin
		resetn = 1'b0;
		sel = 1'b0;
		{awv, wv, br, arv, rr, awa, ara, wd} = '0;
		err_total = 0;
		comparisons = 0;
		void'($urandom(40473));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		chk({31'h0, sda_oe_n}, 32'h1);
		chk({16'h0, dac}, 32'h0);
		sel <= 1'b1;
		axi_rd(8'h00, d, r);
		chk({31'h0, d[0]}, 32'h1);
		v = 16'($urandom);
		u = 16'($urandom);
		exp_q.push_back(v);
		exp_q.push_back(u);
		frame(8'h98, 8'h10, v);
		send(u[15:8], 1'b1);
		send(u[7:0], 1'b1);
		m_u.stop_c();
		m_u.start_c();
		send(8'h99, 1'b1);
		m_u.rd_byte(1'b1, b);
		chk({24'h0, b}, {24'h0, u[15:8]});
		m_u.rd_byte(1'b1, b);
		chk({24'h0, b}, {24'h0, u[7:0]});
		m_u.rd_byte(1'b0, b);
		chk({24'h0, b}, 32'h10);
		m_u.stop_c();
		for (int i = 0; i < 3; i++) begin
			m_u.start_c();
			send(BAD[8*i +: 8], 1'b0);
			m_u.stop_c();
		end
		m_u.start_c();
		send(8'h0d, 1'b0);
		chk({31'h0, hs}, 32'h1);
		v = 16'($urandom);
		exp_q.push_back(v);
		frame(8'h98, 8'h10, v);
		m_u.stop_c();
		chk({31'h0, hs}, 32'h0);
		frame(8'h98, 8'hd0, ~v);
		u = 16'($urandom);
		frame(8'h98, 8'h00, u);
		exp_q.push_back(u);
		frame(8'h98, 8'h20, ~u);
		v = 16'($urandom);
		exp_q.push_back(v);
		frame(8'h90, 8'hf4, v);
		m_u.stop_c();
		axi_wr(8'h00, 32'h0, r);
		m_u.start_c();
		send(8'h98, 1'b0);
		m_u.stop_c();
		axi_wr(8'h00, 32'h1, r);
		axi_rd(8'h08, d, r);
		chk(d, {16'h0, v});
		axi_rd(8'h20, d, r);
		chk({30'h0, r}, 32'h2);
		axi_wr(8'h24, 32'h5, r);
		chk({30'h0, r}, 32'h2);
		frame(8'h98, 8'h01, 16'h6000);
		m_u.stop_c();
		axi_rd(8'h0c, d, r);
		chk({29'h0, d[18:16]}, 32'h3);
		exp_q.push_back(16'h6000);
		frame(8'h98, 8'h20, 16'h0000);
		m_u.stop_c();
		chk({29'h0, pd}, 32'h3);
		// Low byte cut short by a stop must not update
		m_u.start_c();
		send(8'h98, 1'b1);
		send(8'h10, 1'b1);
		send(8'h12, 1'b1);
		for (int i = 0; i < 4; i++)
			m_u.bit_x(1'b0, b[0]);
		m_u.stop_c();
		axi_rd(8'h14, d, r);
		chk(d, 32'h8);
		repeat (10) @(posedge clk);
		chk(exp_q.size(), 0);
		print_verdict();
	end
endmodule
`default_nettype wire
